// >>> src/tapmc_pkg.sv
// constants of the action, alarm-polarity and modem configuration register bank
// assumes a 16-bit register access port fed by the host serial frame decoder
package tapmc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] TAPMC_OFS_SOFT_RESET = 8'h07;
  localparam logic [7:0] TAPMC_OFS_ACTION = 8'h0a;
  localparam logic [7:0] TAPMC_OFS_ALARM_CFG = 8'h0b;
  localparam logic [7:0] TAPMC_OFS_MODEM_CFG = 8'h0e;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int TAPMC_BIT_CONV = 0;
  localparam int TAPMC_BIT_FUSE_LOAD = 1;
  localparam int TAPMC_BIT_MEM_TEST = 2;
  localparam int TAPMC_BIT_AUX_EN = 0;
  localparam int TAPMC_BIT_ALARM_POL = 1;
  localparam int TAPMC_BIT_FUSE_ON_SR = 2;
  localparam int TAPMC_BIT_RX_EXT_FILT = 10;
  localparam int TAPMC_BIT_RX_HORD = 11;
  localparam int TAPMC_BIT_EXT_LOOP = 12;
  localparam int TAPMC_BIT_HIGH_TONE = 15;
  // ----------------------------------------
  // reset values, masks and codes
  // ----------------------------------------
  localparam logic [15:0] TAPMC_ACTION_RST = 16'h0000;
  localparam logic [2:0] TAPMC_ALARM_CFG_RST = 3'h0;
  localparam logic [15:0] TAPMC_MODEM_CFG_RST = 16'h0040;
  localparam logic [15:0] TAPMC_MODEM_CFG_MASK = 16'h9fff;
  localparam logic [7:0] TAPMC_SOFT_RESET_CODE = 8'had;
  localparam logic [1:0] TAPMC_ACT_ALARM_LEVEL = 2'h2;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int TAPMC_SEQ_CYCLES = 64;
endpackage

// >>> src/tapmc_seq_if.sv
// handshake between the register bank and the direct-mode conversion sequencer
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface tapmc_seq_if;
  logic start;
  logic abort;
  logic busy;
  logic done;
  modport ctrl (output start, output abort, input busy, input done);
  modport seq (input start, input abort, output busy, output done);
endinterface
`default_nettype wire

// >>> src/tapmc_seq.sv
// direct-mode conversion sequence timer
// assumes start and abort are single-cycle requests on the core clock
`timescale 1ns/1ps
`default_nettype none
module tapmc_seq
  #(parameter int SEQ_CYCLES = tapmc_pkg::TAPMC_SEQ_CYCLES)
  (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  tapmc_seq_if.seq s
  );
  import tapmc_pkg::*;

  typedef enum logic [0:0] {TAPMC_IDLE = 1'b0, TAPMC_RUN = 1'b1} tapmc_seq_e;
  tapmc_seq_e state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic done_q, done_d;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    case (state_q)
      TAPMC_IDLE:
      begin
        if (s.start)
        begin
          state_d = TAPMC_RUN;
          cnt_d = 16'h0000;
        end
      end
      TAPMC_RUN:
      begin
        // abort ends the sequence early and gives no done
        if (s.abort)
          state_d = TAPMC_IDLE;
        else if (cnt_q == 16'(SEQ_CYCLES - 1))
        begin
          state_d = TAPMC_IDLE;
          done_d = 1'b1;
        end
        else
          cnt_d = cnt_q + 16'h0001;
      end
      default: state_d = TAPMC_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= TAPMC_IDLE;
      cnt_q <= 16'h0000;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign s.busy = (state_q == TAPMC_RUN);
  assign s.done = done_q;

  // the length is a parameter, so the check follows the counter rather than a fixed repeat
  seq_length_a: assert property (@(posedge clk) disable iff (rst)
    s.busy && !s.abort && (cnt_q != 16'(SEQ_CYCLES - 1)) |=> s.busy)
    else $error("sequence ended early");
  seq_abort_a: assert property (@(posedge clk) disable iff (rst)
    s.busy && s.abort |=> !s.busy && !s.done) else $error("abort did not stop sequence");
endmodule
`default_nettype wire

// >>> src/tapmc_regs.sv
// action, alarm-polarity and modem configuration register bank
// assumes a decoded 16-bit register write/read port on the core clock,
// self-test and fuse engines on the same clock, and an asynchronous polarity pin
`timescale 1ns/1ps
`default_nettype none
module tapmc_regs
  #(parameter int SEQ_CYCLES = tapmc_pkg::TAPMC_SEQ_CYCLES)
  (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // engines
  input wire logic mem_test_done,
  input wire logic conv_direct_mode,
  output logic mem_test_start,
  output logic fuse_load_start,
  output logic soft_reset,
  output logic modem_fifo_enable,
  output logic conv_run,
  // alarm and pin
  input wire logic polarity_or_aux_input_pin,
  input wire logic alarm_active,
  input wire logic [1:0] alarm_action,
  output logic effective_alarm_polarity,
  output logic output_force_alarm,
  output logic aux_channel_grounded,
  // modem options
  output logic high_tone_only,
  output logic external_loopback_select,
  output logic rx_high_order_filter_enable,
  output logic rx_external_filter_enable
  );
  import tapmc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  tapmc_seq_if sif ();
  logic pin_meta_q, pin_sync_q;
  logic conv_q, conv_d;
  logic test_busy_q, test_busy_d;
  logic [2:0] alarm_cfg_q, alarm_cfg_d;
  logic [15:0] modem_q, modem_d;
  logic mem_test_start_q, mem_test_start_d;
  logic fuse_load_q, fuse_load_d;
  logic soft_reset_q, soft_reset_d;
  logic conv_run_q, conv_run_d;
  logic eff_pol_q, eff_pol_d;
  logic force_q, force_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q;
  logic fifo_en_q, aux_gnd_q;
  logic wr_action, wr_alarm, wr_modem, wr_reset, srst;

  tapmc_seq #(.SEQ_CYCLES(SEQ_CYCLES)) u_seq (.clk(clk), .rst(srst), .s(sif));

  // pin sampled through two flops; only the second is read
  always_ff @(posedge clk)
  begin
    pin_meta_q <= polarity_or_aux_input_pin;
    pin_sync_q <= pin_meta_q;
    // not reset: the alarm level must follow the pin while reset is held
    eff_pol_q <= eff_pol_d;
  end

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  assign wr_action = reg_wr && (reg_addr == TAPMC_OFS_ACTION);
  assign wr_alarm = reg_wr && (reg_addr == TAPMC_OFS_ALARM_CFG);
  assign wr_modem = reg_wr && (reg_addr == TAPMC_OFS_MODEM_CFG);
  assign wr_reset = reg_wr && (reg_addr == TAPMC_OFS_SOFT_RESET);
  // soft reset returns the bank to defaults one cycle after the code write
  assign srst = rst || soft_reset_q;

  assign sif.start = conv_direct_mode && wr_action && reg_wdata[TAPMC_BIT_CONV] && !sif.busy;
  assign sif.abort = conv_direct_mode && wr_action && !reg_wdata[TAPMC_BIT_CONV];

  always_comb
  begin
    conv_d = conv_q;
    if (wr_action)
      conv_d = reg_wdata[TAPMC_BIT_CONV];
    else if (conv_direct_mode && sif.done)
      conv_d = 1'b0;
    // a new self-test request is ignored until the running one reports done
    mem_test_start_d = wr_action && reg_wdata[TAPMC_BIT_MEM_TEST] && !test_busy_q;
    test_busy_d = mem_test_start_d || (test_busy_q && !mem_test_done);
    soft_reset_d = wr_reset && (reg_wdata[7:0] == TAPMC_SOFT_RESET_CODE);
    fuse_load_d = (wr_action && reg_wdata[TAPMC_BIT_FUSE_LOAD])
      || (soft_reset_d && alarm_cfg_q[TAPMC_BIT_FUSE_ON_SR]);
    alarm_cfg_d = wr_alarm ? reg_wdata[2:0] : alarm_cfg_q;
    modem_d = wr_modem ? (reg_wdata & TAPMC_MODEM_CFG_MASK) : modem_q;
    // mode zero follows the level bit, mode one follows the sequencer
    conv_run_d = conv_direct_mode ? (sif.start || (sif.busy && !sif.abort && !sif.done)) : conv_d;
    eff_pol_d = alarm_cfg_q[TAPMC_BIT_ALARM_POL]
      || (pin_sync_q && !alarm_cfg_q[TAPMC_BIT_AUX_EN]);
    force_d = alarm_active && (alarm_action == TAPMC_ACT_ALARM_LEVEL);
    rdata_d = 16'h0000;
    case (reg_addr)
      TAPMC_OFS_ACTION: rdata_d[TAPMC_BIT_CONV] = conv_q;
      TAPMC_OFS_ALARM_CFG: rdata_d[2:0] = alarm_cfg_q;
      TAPMC_OFS_MODEM_CFG: rdata_d = modem_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      conv_q <= 1'b0;
      test_busy_q <= 1'b0;
      alarm_cfg_q <= TAPMC_ALARM_CFG_RST;
      modem_q <= TAPMC_MODEM_CFG_RST;
      mem_test_start_q <= 1'b0;
      fuse_load_q <= 1'b0;
      conv_run_q <= 1'b0;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      fifo_en_q <= 1'b1;
      aux_gnd_q <= 1'b1;
    end
    else
    begin
      conv_q <= conv_d;
      test_busy_q <= test_busy_d;
      alarm_cfg_q <= alarm_cfg_d;
      modem_q <= modem_d;
      mem_test_start_q <= mem_test_start_d;
      fuse_load_q <= fuse_load_d;
      conv_run_q <= conv_run_d;
      rdata_q <= reg_rd ? rdata_d : rdata_q;
      rvalid_q <= reg_rd;
      fifo_en_q <= !test_busy_d;
      aux_gnd_q <= !alarm_cfg_d[TAPMC_BIT_AUX_EN];
    end
  end

  // reset pulse and alarm force survive the soft reset; only rst resets them, clearing the pulse and setting the force to one
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      soft_reset_q <= 1'b0;
      force_q <= 1'b1;
    end
    else
    begin
      soft_reset_q <= soft_reset_d;
      force_q <= force_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign mem_test_start = mem_test_start_q;
  assign fuse_load_start = fuse_load_q;
  assign soft_reset = soft_reset_q;
  assign modem_fifo_enable = fifo_en_q;
  assign conv_run = conv_run_q;
  assign effective_alarm_polarity = eff_pol_q;
  assign output_force_alarm = force_q;
  assign aux_channel_grounded = aux_gnd_q;
  assign high_tone_only = modem_q[TAPMC_BIT_HIGH_TONE];
  assign external_loopback_select = modem_q[TAPMC_BIT_EXT_LOOP];
  assign rx_high_order_filter_enable = modem_q[TAPMC_BIT_RX_HORD];
  assign rx_external_filter_enable = modem_q[TAPMC_BIT_RX_EXT_FILT];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  mem_test_start_a: assert property (@(posedge clk) disable iff (srst)
    wr_action && reg_wdata[2] && !test_busy_q |=> mem_test_start && !modem_fifo_enable)
    else $error("no test start");
  fifo_held_off_a: assert property (@(posedge clk) disable iff (srst)
    !modem_fifo_enable && !mem_test_done |=> !modem_fifo_enable) else $error("fifo not held");
  fuse_pulse_a: assert property (@(posedge clk) disable iff (srst)
    wr_action && reg_wdata[1] |=> fuse_load_start) else $error("no fuse load");
  auto_level_a: assert property (@(posedge clk) disable iff (srst)
    !conv_direct_mode && wr_action |=> conv_q == $past(reg_wdata[0])) else $error("bad level");
  direct_clear_a: assert property (@(posedge clk) disable iff (srst)
    conv_direct_mode && sif.done && !wr_action |=> !conv_q) else $error("bit not cleared");
  sr_fuse_a: assert property (@(posedge clk) disable iff (rst)
    soft_reset_d |=> fuse_load_start == $past(alarm_cfg_q[2])) else $error("fuse on reset");
  eff_pol_a: assert property (@(posedge clk) disable iff (rst)
    ##1 effective_alarm_polarity == ($past(alarm_cfg_q[1]) || ($past(pin_sync_q)
    && !$past(alarm_cfg_q[0])))) else $error("bad polarity");
  sr_code_a: assert property (@(posedge clk) disable iff (rst)
    soft_reset |-> $past(wr_reset) && $past(reg_wdata[7:0]) == 8'had) else $error("bad reset");
  alarm_force_a: assert property (@(posedge clk) disable iff (rst)
    alarm_active && alarm_action == 2'h2 |=> output_force_alarm) else $error("no force");
  self_clear_a: assert property (@(posedge clk) disable iff (srst)
    reg_rd && reg_addr == 8'h0a |=> reg_rdata[2:1] == 2'h0) else $error("strobe read back");
  cov_test: cover property (@(posedge clk) mem_test_start ##[1:20] mem_test_done);
  cov_direct: cover property (@(posedge clk) sif.start ##[1:100] sif.done);
  cov_abort: cover property (@(posedge clk) sif.busy && sif.abort);
  cov_sreset: cover property (@(posedge clk) soft_reset && fuse_load_start);
endmodule
`default_nettype wire

// >>> bench/tapmc_engine_model.sv
// self-test engine stand-in on the far side of the register bank
// assumes one clock shared with the bank and a one-cycle start pulse
`timescale 1ns/1ps
`default_nettype none
module tapmc_engine_model
  #(parameter int TEST_CYCLES = 8)
  (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // engine handshake
  input wire logic mem_test_start,
  output logic mem_test_done
  );
  int cnt;
  // done pulses a fixed time after start; the sram stays owned until then
  always @(posedge clk)
  begin
    mem_test_done <= 1'b0;
    if (rst)
      cnt <= 0;
    else if (mem_test_start)
      cnt <= TEST_CYCLES;
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      mem_test_done <= (cnt == 1);
    end
  end
endmodule
`default_nettype wire

// >>> bench/trigger_alarm_polarity_modem_cfg_test.sv
// self-checking bench for the action, alarm-polarity and modem configuration bank
// assumes the bank's registered one-cycle answers and a 50 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module trigger_alarm_polarity_modem_cfg_test;
  import tapmc_pkg::*;
  localparam int SEQ = 4;
  logic clk, rst, reg_wr, reg_rd, mem_test_done, conv_direct_mode, pin, alarm_active;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0] alarm_action;
  logic reg_rvalid, mem_test_start, fuse_load_start, soft_reset, modem_fifo_enable, conv_run;
  logic eff_pol, force_alarm, aux_gnd, hto, ext_loop, hord, ext_filt;
  int errors = 0, checks_done = 0, cycles = 0, fl_cnt = 0, sr_cnt = 0;
  tapmc_regs #(.SEQ_CYCLES(SEQ)) dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mem_test_done(mem_test_done), .conv_direct_mode(conv_direct_mode),
    .mem_test_start(mem_test_start), .fuse_load_start(fuse_load_start),
    .soft_reset(soft_reset), .modem_fifo_enable(modem_fifo_enable), .conv_run(conv_run),
    .polarity_or_aux_input_pin(pin), .alarm_active(alarm_active), .alarm_action(alarm_action),
    .effective_alarm_polarity(eff_pol), .output_force_alarm(force_alarm),
    .aux_channel_grounded(aux_gnd), .high_tone_only(hto), .external_loopback_select(ext_loop),
    .rx_high_order_filter_enable(hord), .rx_external_filter_enable(ext_filt));
  tapmc_engine_model eng (.clk(clk), .rst(rst), .mem_test_start(mem_test_start),
    .mem_test_done(mem_test_done));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // pulse counters, so windows of unknown length can be judged afterwards
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (fuse_load_start === 1'b1) fl_cnt <= fl_cnt + 1;
    if (soft_reset === 1'b1) sr_cnt <= sr_cnt + 1;
    if (cycles == 3000)
    begin
      errors = errors + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(posedge clk) #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge clk) #1;
    reg_rd = 1'b1; reg_addr = a;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    chk({15'h0, reg_rvalid}, 16'h0001, "rvalid");
    chk(reg_rdata, exp, what);
  endtask
  task automatic t_reset_values();
    rd(TAPMC_OFS_ACTION, 16'h0000, "action rst");
    rd(TAPMC_OFS_ALARM_CFG, 16'h0000, "alarm cfg rst");
    rd(TAPMC_OFS_MODEM_CFG, 16'h0040, "modem cfg rst");
    rd(8'h01, 16'h0000, "unmapped");
  endtask
  task automatic t_mem_test();
    int n;
    wr(TAPMC_OFS_ACTION, 16'h0004);
    chk({15'h0, mem_test_start}, 16'h0001, "test start");
    chk({15'h0, modem_fifo_enable}, 16'h0000, "fifo held");
    rd(TAPMC_OFS_ACTION, 16'h0000, "test bit clear");
    for (n = 0; n < 30 && modem_fifo_enable !== 1'b1; n++) @(posedge clk) #1;
    chk({15'h0, modem_fifo_enable}, 16'h0001, "fifo back");
  endtask
  task automatic t_fuse();
    int f;
    f = fl_cnt;
    wr(TAPMC_OFS_ACTION, 16'h0002);
    chk({15'h0, fuse_load_start}, 16'h0001, "fuse start");
    rd(TAPMC_OFS_ACTION, 16'h0000, "fuse bit clear");
    wr(TAPMC_OFS_ACTION, 16'h0002);
    @(posedge clk) #1;
    chk(16'(fl_cnt - f), 16'h0002, "fuse retry");
  endtask
  task automatic t_conv();
    conv_direct_mode = 1'b0;
    wr(TAPMC_OFS_ACTION, 16'h0001);
    repeat (SEQ * 5) @(posedge clk) #1;
    chk({15'h0, conv_run}, 16'h0001, "auto runs");
    wr(TAPMC_OFS_ACTION, 16'h0000);
    chk({15'h0, conv_run}, 16'h0000, "auto halts");
    conv_direct_mode = 1'b1;
    wr(TAPMC_OFS_ACTION, 16'h0001);
    chk({15'h0, conv_run}, 16'h0001, "direct runs");
    rd(TAPMC_OFS_ACTION, 16'h0001, "direct bit set");
    repeat (SEQ + 4) @(posedge clk) #1;
    rd(TAPMC_OFS_ACTION, 16'h0000, "direct self clear");
    chk({15'h0, conv_run}, 16'h0000, "direct ended");
    wr(TAPMC_OFS_ACTION, 16'h0001);
    wr(TAPMC_OFS_ACTION, 16'h0000);
    chk({15'h0, conv_run}, 16'h0000, "abort");
    conv_direct_mode = 1'b0;
  endtask
  task automatic t_polarity();
    logic [2:0] i;
    int a;
    for (int k = 0; k < 8; k++)
    begin
      i = 3'(k);
      pin = i[2];
      wr(TAPMC_OFS_ALARM_CFG, {14'h0, i[1], i[0]});
      repeat (4) @(posedge clk) #1;
      chk({15'h0, eff_pol}, {15'h0, i[1] | (i[2] & ~i[0])}, "polarity");
      chk({15'h0, aux_gnd}, {15'h0, ~i[0]}, "aux ground");
    end
    alarm_active = 1'b1;
    for (a = 0; a < 4; a++)
    begin
      alarm_action = 2'(a);
      repeat (2) @(posedge clk) #1;
      chk({15'h0, force_alarm}, {15'h0, a == 2}, "alarm action");
    end
    alarm_active = 1'b0;
    repeat (2) @(posedge clk) #1;
    chk({15'h0, force_alarm}, 16'h0000, "alarm idle");
  endtask
  task automatic t_modem();
    wr(TAPMC_OFS_MODEM_CFG, 16'hffff);
    rd(TAPMC_OFS_MODEM_CFG, 16'h9fff, "modem cfg");
    chk({12'h0, hto, ext_loop, hord, ext_filt}, 16'h000f, "modem pins");
    wr(TAPMC_OFS_MODEM_CFG, 16'h1400);
    chk({12'h0, hto, ext_loop, hord, ext_filt}, 16'h0005, "modem mix");
    wr(TAPMC_OFS_MODEM_CFG, 16'h0840);
    chk({12'h0, hto, ext_loop, hord, ext_filt}, 16'h0002, "modem hord");
  endtask
  task automatic t_soft_reset();
    int f, s;
    wr(TAPMC_OFS_ALARM_CFG, 16'h0004);
    f = fl_cnt; s = sr_cnt;
    wr(TAPMC_OFS_SOFT_RESET, 16'h00ac);
    wr(TAPMC_OFS_SOFT_RESET, 16'h00ad);
    repeat (4) @(posedge clk) #1;
    chk(16'(sr_cnt - s), 16'h0001, "soft reset code");
    chk(16'(fl_cnt - f), 16'h0001, "reload on reset");
    rd(TAPMC_OFS_ALARM_CFG, 16'h0000, "cfg default");
    rd(TAPMC_OFS_MODEM_CFG, 16'h0040, "modem default");
    wr(TAPMC_OFS_SOFT_RESET, 16'h00ad);
    repeat (4) @(posedge clk) #1;
    chk(16'(fl_cnt - f), 16'h0001, "no reload");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 16'h0000;
    conv_direct_mode = 1'b0; pin = 1'b1; alarm_active = 1'b0; alarm_action = 2'h0;
    repeat (20) @(posedge clk);
    #1;
    chk({15'h0, force_alarm}, 16'h0001, "force in reset");
    chk({15'h0, eff_pol}, 16'h0001, "polarity in reset");
    pin = 1'b0;
    rst = 1'b0;
    t_reset_values();
    t_mem_test();
    t_fuse();
    t_conv();
    t_polarity();
    t_modem();
    t_soft_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
